/* core/button_timer.sv */
`timescale 1ns/1ns
// Debounces the set button; reports a short press on release and a long press once the long hold is reached.
module button_timer #(
   parameter int unsigned DEBOUNCE = stick_cfg_pkg::DEBOUNCE_CYC,
   parameter int unsigned SHORT_HOLD = stick_cfg_pkg::SHORT_PRESS_CYC,
   parameter int unsigned LONG_HOLD = stick_cfg_pkg::LONG_PRESS_CYC
) (
   input wire logic clk,
   input wire logic rstN,
   input wire logic buttonPin,
   output logic shortPress,
   output logic longPress
);
   localparam int W = $clog2(LONG_HOLD + 1);
   // The bounce counter shares the hold width, so debounce may not exceed the long hold.
   localparam bit HOLD_BAD = SHORT_HOLD == 0 || LONG_HOLD <= SHORT_HOLD ||
      DEBOUNCE == 0 || DEBOUNCE > LONG_HOLD;
   if (HOLD_BAD) begin : g_bad_hold
      $error("button_timer: bad hold thresholds");
   end
   logic [2:0] sync;
   logic stable, next_stable;
   logic [W-1:0] bounce, next_bounce;
   logic [W-1:0] hold, next_hold;
   logic longSeen, next_longSeen;
   logic next_shortPress, next_longPress;

   always_comb begin
      next_stable = stable;
      next_bounce = '0;
      next_hold = hold;
      next_longSeen = longSeen;
      next_shortPress = 1'b0;
      next_longPress = 1'b0;
      // Only the agreeing second and third stages are looked at.
      if (sync[2] == sync[1] && sync[2] != stable) begin
         next_bounce = bounce + W'(1);
         if (bounce == W'(DEBOUNCE - 1)) begin
            next_stable = sync[2];
            next_bounce = '0;
         end
      end
      if (stable) begin
         if (hold != W'(LONG_HOLD)) begin
            next_hold = hold + W'(1);
         end
         // Long action fires at the threshold so write-out mode starts while held.
         if (hold == W'(LONG_HOLD - 1) && !longSeen) begin
            next_longPress = 1'b1;
            next_longSeen = 1'b1;
         end
      end else begin
         next_shortPress = !longSeen && hold >= W'(SHORT_HOLD);
         next_hold = '0;
         next_longSeen = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         sync <= 3'h0;
         stable <= 1'b0;
         bounce <= '0;
         hold <= '0;
         longSeen <= 1'b0;
         shortPress <= 1'b0;
         longPress <= 1'b0;
      end else begin
         sync <= {sync[1:0], buttonPin};
         stable <= next_stable;
         bounce <= next_bounce;
         hold <= next_hold;
         longSeen <= next_longSeen;
         shortPress <= next_shortPress;
         longPress <= next_longPress;
      end
   end

   a_press_excl: assert property (@(posedge clk) disable iff (!rstN)
      !(shortPress && longPress)) else $error("short and long press together");
endmodule : button_timer

/* core/stick_cfg_pkg.sv */
package stick_cfg_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned SHORT_PRESS_MS = 1000;
   localparam int unsigned LONG_PRESS_MS = 6000;
   localparam int unsigned DEBOUNCE_MS = 20;
   localparam int unsigned FLASH_MS = 250;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
   localparam int unsigned SHORT_PRESS_CYC = SHORT_PRESS_MS * CYC_PER_MS;
   localparam int unsigned LONG_PRESS_CYC = LONG_PRESS_MS * CYC_PER_MS;
   localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
   localparam int unsigned FLASH_CYC = FLASH_MS * CYC_PER_MS;
   localparam int unsigned BAR_COUNT = 4;
   localparam logic [1:0] STICK_NONE = 2'h0;
   localparam logic [1:0] STICK_KEY = 2'h1;
   localparam logic [1:0] STICK_MEMORY = 2'h2;
   localparam logic [3:0] BAR_BOTTOM = 4'h1;
   localparam logic [3:0] BAR_STATIC = 4'hf;

   typedef enum logic [1:0] {
      XFER_KEY_READ = 2'h0,
      XFER_COMMON_READ = 2'h1,
      XFER_FULL_READ = 2'h2,
      XFER_FULL_WRITE = 2'h3
   } xfer_kind_t;

   typedef struct packed {
      logic start;
      xfer_kind_t kind;
   } xfer_req_t;

   typedef struct packed {
      logic done;
      logic error;
   } xfer_resp_t;

   typedef struct packed {
      logic transfer;
      logic fault;
      logic [3:0] bar;
   } led_t;
endpackage : stick_cfg_pkg

/* core/stick_config_transfer_ctrl.sv */
`timescale 1ns/1ns
// How it works
// - Key stick plus one-second press reads key.
// - Finished short read: transfer LED once, apply.
// - Accepted key parameters committed to internal memory.
// - Six-second press, no stick: write-out, bars run.
// - Write-out starts automatically on memory stick insertion.
// - Write-out done: bar sequence stops static.
// - Write or verify error: flash both together.
// - Full write copies common and station parameters.
// - Memory stick short press: common parameters only.
// - Memory stick long press: full read, flashing.
// - Full read done: stop flashing, apply all.
module stick_config_transfer_ctrl #(
   parameter int unsigned DEBOUNCE = stick_cfg_pkg::DEBOUNCE_CYC,
   parameter int unsigned SHORT_HOLD = stick_cfg_pkg::SHORT_PRESS_CYC,
   parameter int unsigned LONG_HOLD = stick_cfg_pkg::LONG_PRESS_CYC,
   parameter int unsigned FLASH = stick_cfg_pkg::FLASH_CYC
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic setButton,
   input wire logic [1:0] stickType,
   input wire logic xferDone,
   input wire logic xferError,
   input wire logic [2:0] keyBand,
   output stick_cfg_pkg::xfer_req_t xferReq,
   output logic commitNvm,
   output logic applyCommon,
   output logic applyStation,
   output logic keyBandBad,
   output stick_cfg_pkg::led_t leds
);
   localparam int FW = $clog2(FLASH + 1);
   if (FLASH == 0) begin : g_bad_flash
      $error("stick_config_transfer_ctrl: FLASH must be nonzero");
   end

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_READ = 3'h1,
      ST_WAIT_STICK = 3'h2,
      ST_WRITE = 3'h3,
      ST_FAULT = 3'h4
   } state_t;

   logic [1:0] rstSync;
   logic rstN;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rstSync <= 2'h0;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end
   assign rstN = rstSync[1];

   logic shortPress, longPress;
   button_timer #(.DEBOUNCE(DEBOUNCE), .SHORT_HOLD(SHORT_HOLD), .LONG_HOLD(LONG_HOLD))
   i_button_timer (
      .clk(clk),
      .rstN(rstN),
      .buttonPin(setButton),
      .shortPress(shortPress),
      .longPress(longPress)
   );

   // Stick presence comes from a pin, so three stages and agreement.
   logic [1:0] stS0, stS1, stS2, stick, next_stick;
   always_comb begin
      next_stick = (stS1 == stS2) ? stS2 : stick;
   end

   state_t state, next_state;
   stick_cfg_pkg::xfer_kind_t kind, next_kind;
   stick_cfg_pkg::xfer_req_t next_xferReq;
   stick_cfg_pkg::led_t next_leds;
   logic next_commitNvm, next_applyCommon, next_applyStation, next_keyBandBad;
   logic [FW-1:0] flashCnt, next_flashCnt;
   logic flashTick;
   logic oneShot, next_oneShot;

   assign flashTick = (flashCnt == FW'(FLASH - 1));

   function automatic logic band_ok(input logic [2:0] b);
      band_ok = (b == 3'h3) || (b == 3'h5) || (b == 3'h7);
   endfunction : band_ok

   always_comb begin
      next_state = state;
      next_kind = kind;
      next_xferReq = '0;
      next_xferReq.kind = kind;
      next_leds = leds;
      next_commitNvm = 1'b0;
      next_applyCommon = 1'b0;
      next_applyStation = 1'b0;
      next_keyBandBad = keyBandBad;
      next_oneShot = 1'b0;
      next_flashCnt = flashTick ? '0 : flashCnt + FW'(1);
      case (state)
         ST_IDLE: begin
            // The single transfer light stays for one flash period.
            if (oneShot || !flashTick) begin
               next_oneShot = oneShot && !flashTick;
            end
            if (!next_oneShot) begin
               next_leds.transfer = 1'b0;
            end
            if (shortPress && stick == stick_cfg_pkg::STICK_KEY) begin
               next_kind = stick_cfg_pkg::XFER_KEY_READ;
               next_state = ST_READ;
            end else if (shortPress && stick == stick_cfg_pkg::STICK_MEMORY) begin
               next_kind = stick_cfg_pkg::XFER_COMMON_READ;
               next_state = ST_READ;
            end else if (longPress && stick == stick_cfg_pkg::STICK_MEMORY) begin
               next_kind = stick_cfg_pkg::XFER_FULL_READ;
               next_state = ST_READ;
            end else if (longPress && stick == stick_cfg_pkg::STICK_NONE) begin
               next_state = ST_WAIT_STICK;
               next_leds.bar = stick_cfg_pkg::BAR_BOTTOM;
            end
            if (next_state == ST_READ) begin
               next_xferReq.start = 1'b1;
               next_xferReq.kind = next_kind;
               next_leds = '0;
               next_flashCnt = '0;
            end
         end
         ST_READ: begin
            if (kind == stick_cfg_pkg::XFER_FULL_READ && flashTick) begin
               next_leds.transfer = !leds.transfer;
            end
            if (xferError) begin
               next_state = ST_FAULT;
               next_leds = '0;
            end else if (xferDone) begin
               next_state = ST_IDLE;
               next_commitNvm = 1'b1;
               next_applyCommon = 1'b1;
               next_applyStation = (kind == stick_cfg_pkg::XFER_FULL_READ);
               next_leds.transfer = (kind != stick_cfg_pkg::XFER_FULL_READ);
               next_oneShot = next_leds.transfer;
               next_flashCnt = '0;
               if (kind == stick_cfg_pkg::XFER_KEY_READ) begin
                  next_keyBandBad = !band_ok(keyBand);
               end
            end
         end
         ST_WAIT_STICK, ST_WRITE: begin
            if (flashTick) begin
               next_leds.bar = {leds.bar[2:0], leds.bar[3]};
            end
            if (state == ST_WAIT_STICK && stick == stick_cfg_pkg::STICK_MEMORY) begin
               next_state = ST_WRITE;
               next_kind = stick_cfg_pkg::XFER_FULL_WRITE;
               next_xferReq.start = 1'b1;
               next_xferReq.kind = stick_cfg_pkg::XFER_FULL_WRITE;
            end
            if (state == ST_WRITE && xferError) begin
               next_state = ST_FAULT;
               next_leds = '0;
            end else if (state == ST_WRITE && xferDone) begin
               next_state = ST_IDLE;
               next_leds.bar = stick_cfg_pkg::BAR_STATIC;
            end
         end
         ST_FAULT: begin
            // Fault flashing holds until the stick is pulled out.
            if (flashTick) begin
               next_leds.transfer = !leds.transfer;
               next_leds.fault = !leds.transfer;
            end
            if (stick == stick_cfg_pkg::STICK_NONE) begin
               next_state = ST_IDLE;
               next_leds = '0;
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_leds = '0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         stS0 <= stick_cfg_pkg::STICK_NONE;
         stS1 <= stick_cfg_pkg::STICK_NONE;
         stS2 <= stick_cfg_pkg::STICK_NONE;
         stick <= stick_cfg_pkg::STICK_NONE;
         state <= ST_IDLE;
         kind <= stick_cfg_pkg::XFER_KEY_READ;
         xferReq <= '0;
         leds <= '0;
         commitNvm <= 1'b0;
         applyCommon <= 1'b0;
         applyStation <= 1'b0;
         keyBandBad <= 1'b0;
         flashCnt <= '0;
         oneShot <= 1'b0;
      end else begin
         stS0 <= stickType;
         stS1 <= stS0;
         stS2 <= stS1;
         stick <= next_stick;
         state <= next_state;
         kind <= next_kind;
         xferReq <= next_xferReq;
         leds <= next_leds;
         commitNvm <= next_commitNvm;
         applyCommon <= next_applyCommon;
         applyStation <= next_applyStation;
         keyBandBad <= next_keyBandBad;
         flashCnt <= next_flashCnt;
         oneShot <= next_oneShot;
      end
   end

   a_commit_apply: assert property (@(posedge clk) disable iff (!rstN)
      commitNvm |-> applyCommon) else $error("commit without apply");
   a_common_only: assert property (@(posedge clk) disable iff (!rstN)
      applyStation |-> $past(kind) == stick_cfg_pkg::XFER_FULL_READ)
      else $error("station parameters applied outside full read");
   a_short_start: assert property (@(posedge clk) disable iff (!rstN)
      (state == ST_IDLE && shortPress && stick == stick_cfg_pkg::STICK_KEY) |=>
      xferReq.start && xferReq.kind == stick_cfg_pkg::XFER_KEY_READ)
      else $error("key read not started");
   a_write_auto: assert property (@(posedge clk) disable iff (!rstN)
      (state == ST_WAIT_STICK && stick == stick_cfg_pkg::STICK_MEMORY) |=>
      state == ST_WRITE && xferReq.start) else $error("write-out not started");
   a_write_static: assert property (@(posedge clk) disable iff (!rstN)
      (state == ST_WRITE && xferDone && !xferError) |=>
      leds.bar == stick_cfg_pkg::BAR_STATIC) else $error("bars not static");
   a_fault_sync: assert property (@(posedge clk) disable iff (!rstN)
      state == ST_FAULT && $past(state) == ST_FAULT |-> leds.transfer == leds.fault)
      else $error("fault LEDs out of step");
   a_bar_onehot: assert property (@(posedge clk) disable iff (!rstN)
      state == ST_WAIT_STICK |-> $onehot(leds.bar)) else $error("bar sequence broken");
   a_full_noflash: assert property (@(posedge clk) disable iff (!rstN)
      (state == ST_READ && kind == stick_cfg_pkg::XFER_FULL_READ && xferDone && !xferError)
      |=> !leds.transfer && applyStation) else $error("full read end wrong");
   a_short_once: assert property (@(posedge clk) disable iff (!rstN)
      (state == ST_READ && kind == stick_cfg_pkg::XFER_COMMON_READ && xferDone && !xferError)
      |=> leds.transfer && applyCommon) else $error("short read end wrong");
endmodule : stick_config_transfer_ctrl

/* tb/stick_config_transfer_ctrl_tb_top.sv */
`timescale 1ns/1ns
module stick_config_transfer_ctrl_tb_top;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic setButton = 1'b0;
   logic [1:0] stickType = 2'h0;
   logic failNext = 1'b0;
   logic [2:0] band = 3'h3;
   logic [7:0] delay = 8'h14;
   logic xferDone, xferError, commitNvm, applyCommon, applyStation, keyBandBad;
   logic [2:0] keyBand;
   logic [3:0] b;
   stick_cfg_pkg::xfer_req_t xferReq;
   stick_cfg_pkg::led_t leds;
   int miscompares = 0;
   int total_checks = 0;
   int nStart, nCommit, nCommon, nStation, nTRise, nFRise;
   logic [1:0] kind;
   logic prevT, prevF;
   initial forever #5 clk = ~clk;
   stick_config_transfer_ctrl #(.DEBOUNCE(4), .SHORT_HOLD(50), .LONG_HOLD(200), .FLASH(8))
   i_stick_config_transfer_ctrl (.clk(clk), .reset_n(reset_n), .setButton(setButton),
      .stickType(stickType), .xferDone(xferDone), .xferError(xferError), .keyBand(keyBand),
      .xferReq(xferReq), .commitNvm(commitNvm), .applyCommon(applyCommon),
      .applyStation(applyStation), .keyBandBad(keyBandBad), .leds(leds));
   stick_partner i_stick_partner (.clk(clk), .xferReq(xferReq), .stickType(stickType),
      .failNext(failNext), .band(band), .delay(delay), .xferDone(xferDone),
      .xferError(xferError), .keyBand(keyBand));
   // One-cycle pulses are counted here so scenarios can judge them afterwards.
   always @(posedge clk) begin
      prevT <= leds.transfer;
      prevF <= leds.fault;
      if (xferReq.start === 1'b1) begin
         nStart <= nStart + 1;
         kind <= xferReq.kind;
      end
      if (commitNvm === 1'b1) nCommit <= nCommit + 1;
      if (applyCommon === 1'b1) nCommon <= nCommon + 1;
      if (applyStation === 1'b1) nStation <= nStation + 1;
      if (leds.transfer === 1'b1 && prevT === 1'b0) nTRise <= nTRise + 1;
      if (leds.fault === 1'b1 && prevF === 1'b0) nFRise <= nFRise + 1;
   end
   task automatic results;
      if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   task automatic clear;
      @(negedge clk);
      {nStart, nCommit, nCommon, nStation, nTRise, nFRise} = '0;
   endtask : clear
   // The stick input needs a few cycles through its synchroniser before a press.
   task automatic insert(input logic [1:0] t);
      stickType = t;
      cyc(10);
   endtask : insert
   task automatic press(input int n);
      setButton = 1'b1;
      cyc(n);
      setButton = 1'b0;
   endtask : press
   task automatic waitStart;
      for (int i = 0; i < 400 && nStart == 0; i++) cyc(1);
      if (nStart == 0) begin
         miscompares++;
         results();
      end
   endtask : waitStart
   task automatic keyRead(input logic [2:0] bnd, input logic bad);
      band = bnd;
      insert(stick_cfg_pkg::STICK_KEY);
      clear();
      press(80);
      waitStart();
      check(kind, stick_cfg_pkg::XFER_KEY_READ);
      cyc(40);
      check(nCommit, 1);
      check(nCommon, 1);
      check(nStation, 0);
      check(nTRise, 1);
      check(keyBandBad, bad);
      insert(stick_cfg_pkg::STICK_NONE);
   endtask : keyRead
   task automatic ignored;
      insert(stick_cfg_pkg::STICK_MEMORY);
      clear();
      press(20);
      cyc(30);
      check(nStart, 0);
      insert(stick_cfg_pkg::STICK_KEY);
      press(260);
      cyc(30);
      check(nStart, 0);
      insert(stick_cfg_pkg::STICK_NONE);
   endtask : ignored
   task automatic commonRead;
      insert(stick_cfg_pkg::STICK_MEMORY);
      clear();
      press(80);
      waitStart();
      check(kind, stick_cfg_pkg::XFER_COMMON_READ);
      cyc(40);
      check(nCommon, 1);
      check(nStation, 0);
      check(nTRise, 1);
   endtask : commonRead
   task automatic fullRead;
      delay = 8'h96;
      clear();
      press(260);
      waitStart();
      check(kind, stick_cfg_pkg::XFER_FULL_READ);
      cyc(40);
      check(nTRise > 1, 1);
      check(nStation, 0);
      cyc(80);
      check(nStation, 1);
      check(nCommon, 1);
      check(leds.transfer, 1'b0);
      delay = 8'h14;
      insert(stick_cfg_pkg::STICK_NONE);
   endtask : fullRead
   task automatic writeOut(input logic fail);
      failNext = fail;
      clear();
      press(260);
      b = leds.bar;
      check($countones(b), 1);
      for (int i = 0; i < 20 && leds.bar === b; i++) cyc(1);
      check(leds.bar, {b[2:0], b[3]});
      check(nStart, 0);
      insert(stick_cfg_pkg::STICK_MEMORY);
      check(nStart, 1);
      check(kind, stick_cfg_pkg::XFER_FULL_WRITE);
      cyc(30);
      if (!fail) check(leds.bar, stick_cfg_pkg::BAR_STATIC);
      for (int i = 0; i < 12 && fail; i++) begin
         check(leds.fault, leds.transfer);
         cyc(4);
      end
      if (fail) check(nFRise > 1, 1);
      insert(stick_cfg_pkg::STICK_NONE);
      failNext = 1'b0;
   endtask : writeOut
   // A failed read must commit and apply nothing and fall into fault flashing.
   task automatic readFail;
      insert(stick_cfg_pkg::STICK_MEMORY);
      failNext = 1'b1;
      clear();
      press(80);
      waitStart();
      cyc(40);
      check(nCommit, 0);
      check(nCommon, 0);
      check(nFRise > 0, 1);
      check(leds.fault, leds.transfer);
      insert(stick_cfg_pkg::STICK_NONE);
      failNext = 1'b0;
   endtask : readFail
   initial begin
      cyc(4);
      reset_n = 1'b1;
      cyc(10);
      keyRead(3'h5, 1'b0);
      keyRead(3'h4, 1'b1);
      ignored();
      commonRead();
      fullRead();
      writeOut(1'b0);
      writeOut(1'b1);
      readFail();
      check(leds.fault, 1'b0);
      results();
   end
endmodule : stick_config_transfer_ctrl_tb_top

/* tb/stick_partner.sv */
`timescale 1ns/1ns
// Transfer engine and stick model: answers each start after delay cycles.
module stick_partner (
   input wire logic clk,
   input wire stick_cfg_pkg::xfer_req_t xferReq,
   input wire logic [1:0] stickType,
   input wire logic failNext,
   input wire logic [2:0] band,
   input wire logic [7:0] delay,
   output logic xferDone,
   output logic xferError,
   output logic [2:0] keyBand
);
   logic [7:0] count = 8'h00;
   initial xferDone = 1'b0;
   initial xferError = 1'b0;
   // Band lines float without the key stick, so they show the inverse.
   assign keyBand = (stickType == stick_cfg_pkg::STICK_KEY) ? band : ~band;
   always @(negedge clk) begin
      xferDone <= (count == 8'h01) && !failNext;
      xferError <= (count == 8'h01) && failNext;
      if (xferReq.start === 1'b1) count <= delay;
      else if (count != 8'h00) count <= count - 8'h01;
   end
endmodule : stick_partner
